// >>> rtl/charger_detect_sw_takeover.sv
// Purpose: Charger detection control with software takeover of the flag pin
// Assumes: Classic Wishbone master; sense inputs are asynchronous pins
// Notes: Control register at CTRL_OFFSET, configuration at CFG_OFFSET
`timescale 1ns/1ps
`default_nettype none
module charger_detect_sw_takeover (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [chgdet_pkg::ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic [3:0] sel_i,
  input wire logic we_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  input wire chgdet_pkg::sense_in_s detect_sense_i,
  output logic charger_flag_pin_o,
  output logic charger_flag_pin_oe_o,
  output logic dplus_source_voltage_on_o,
  output logic detect_circuit_en_o
);

  function automatic logic src_active(input chgdet_pkg::det_state_e s, input logic dead);
    src_active = (s == chgdet_pkg::det_source) || (s == chgdet_pkg::det_sample) ||
                 ((s == chgdet_pkg::det_done) && dead);
  endfunction

  // Synchronised sense inputs
  chgdet_pkg::sense_in_s sense_s;
  logic [chgdet_pkg::SYNC_W-1:0] sense_raw;

  pin_sync u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(detect_sense_i),
    .sync_o(sense_raw)
  );

  assign sense_s = chgdet_pkg::sense_in_s'(sense_raw);

  // Bus slave state
  logic ack_d;
  logic [31:0] rdata_d;
  logic ctrl_sel;
  logic cfg_sel;
  logic wr_ctrl;
  logic wr_cfg;
  logic [7:0] ctrl_view;

  // Control state
  chgdet_pkg::ctrl_s ctrl_q;
  chgdet_pkg::ctrl_s ctrl_d;
  chgdet_pkg::cfg_s cfg_q;
  chgdet_pkg::cfg_s cfg_d;
  logic manual_prev_q;
  logic keep_q;
  logic keep_d;
  logic takeover_rise;
  logic port_found;

  // Detection machine state
  chgdet_pkg::det_state_e state_q;
  chgdet_pkg::det_state_e state_d;
  logic [chgdet_pkg::CNT_W-1:0] cnt_q;
  logic [chgdet_pkg::CNT_W-1:0] cnt_d;
  logic hw_found_q;
  logic hw_found_d;
  logic dead_started_q;
  logic dead_started_d;
  logic src_on;

  // Pin outputs
  chgdet_pkg::pins_s pins_q;
  chgdet_pkg::pins_s pins_d;

  assign ctrl_sel = (adr_i == chgdet_pkg::CTRL_OFFSET);
  assign cfg_sel = (adr_i == chgdet_pkg::CFG_OFFSET);
  // Write lands on the edge where the master sees ack
  assign wr_ctrl = cyc_i && stb_i && we_i && ack_o && ctrl_sel && sel_i[0];
  assign wr_cfg = cyc_i && stb_i && we_i && ack_o && cfg_sel && sel_i[0];

  assign takeover_rise = ctrl_q.manual_takeover && !manual_prev_q;
  assign port_found = ctrl_q.charger_indication && !ctrl_q.manual_takeover;
  assign src_on = src_active(state_q, dead_started_q);

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[chgdet_pkg::MANUAL_BIT] = ctrl_q.manual_takeover;
    ctrl_view[chgdet_pkg::FOUND_BIT] = port_found;
    ctrl_view[chgdet_pkg::SPARE_HI:chgdet_pkg::SPARE_LO] = ctrl_q.spare;
    ctrl_view[chgdet_pkg::DM_ABOVE_BIT] = sense_s.dm_above_ref;
    ctrl_view[chgdet_pkg::SENSE_BIT] = ctrl_q.dplus_sense_source_enable;
    ctrl_view[chgdet_pkg::IND_BIT] = ctrl_q.charger_indication;
  end

  // Wishbone slave: ack one cycle after request, unmapped reads zero
  always_comb begin
    ack_d = cyc_i && stb_i && !ack_o;
    rdata_d = dat_o;
    if (cyc_i && stb_i && !ack_o) begin
      rdata_d = 32'h0000_0000;
      if (ctrl_sel) begin
        rdata_d[7:0] = ctrl_view;
      end else if (cfg_sel) begin
        rdata_d[chgdet_pkg::POL_BIT] = cfg_q.flag_pin_polarity;
        rdata_d[chgdet_pkg::DET_EN_BIT] = cfg_q.detect_enable;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= ack_d;
      dat_o <= rdata_d;
    end
  end

  // Control register and takeover capture
  always_comb begin
    ctrl_d = ctrl_q;
    cfg_d = cfg_q;
    keep_d = keep_q;
    if (wr_ctrl) begin
      ctrl_d.manual_takeover = dat_i[chgdet_pkg::MANUAL_BIT];
      ctrl_d.spare = dat_i[chgdet_pkg::SPARE_HI:chgdet_pkg::SPARE_LO];
      // software owns bits once taken over
      if (ctrl_q.manual_takeover) begin
        ctrl_d.charger_indication = dat_i[chgdet_pkg::IND_BIT];
        ctrl_d.dplus_sense_source_enable = dat_i[chgdet_pkg::SENSE_BIT];
      end
    end
    if (wr_cfg) begin
      cfg_d.flag_pin_polarity = dat_i[chgdet_pkg::POL_BIT];
      cfg_d.detect_enable = dat_i[chgdet_pkg::DET_EN_BIT];
    end
    // hardware owns sense enable without takeover
    if (!ctrl_q.manual_takeover) begin
      ctrl_d.charger_indication = hw_found_q;
      ctrl_d.dplus_sense_source_enable = src_on;
      keep_d = 1'b0;
    end
    if (takeover_rise) begin
      ctrl_d.charger_indication = hw_found_q;
      ctrl_d.dplus_sense_source_enable = src_on;
      keep_d = dead_started_q && (state_q != chgdet_pkg::detect_idle_state);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= '{charger_indication: chgdet_pkg::CTRL_BIT_RESET,
                  dplus_sense_source_enable: chgdet_pkg::CTRL_BIT_RESET,
                  spare: chgdet_pkg::SPARE_RESET,
                  manual_takeover: chgdet_pkg::CTRL_BIT_RESET};
      cfg_q <= '{flag_pin_polarity: chgdet_pkg::CFG_BIT_RESET,
                 detect_enable: chgdet_pkg::CFG_BIT_RESET};
      manual_prev_q <= chgdet_pkg::CTRL_BIT_RESET;
      keep_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      cfg_q <= cfg_d;
      manual_prev_q <= ctrl_q.manual_takeover;
      keep_q <= keep_d;
    end
  end

  // Automatic detection: source, settle, sample, hold result
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    hw_found_d = hw_found_q;
    dead_started_d = dead_started_q;
    if (ctrl_q.manual_takeover) begin
      state_d = chgdet_pkg::detect_idle_state;
      cnt_d = '0;
      hw_found_d = 1'b0;
      dead_started_d = 1'b0;
    end else begin
      unique case (state_q)
        chgdet_pkg::detect_idle_state: begin
          hw_found_d = 1'b0;
          cnt_d = '0;
          if (cfg_q.detect_enable || sense_s.dead_battery) begin
            state_d = chgdet_pkg::det_source;
            dead_started_d = sense_s.dead_battery;
          end
        end
        chgdet_pkg::det_source: begin
          cnt_d = cnt_q + 1'b1;
          if (cnt_q == chgdet_pkg::SETTLE_LAST) begin
            state_d = chgdet_pkg::det_sample;
          end
        end
        chgdet_pkg::det_sample: begin
          hw_found_d = sense_s.dm_above_ref;
          state_d = chgdet_pkg::det_done;
        end
        chgdet_pkg::det_done: begin
          if (!cfg_q.detect_enable && !sense_s.dead_battery) begin
            state_d = chgdet_pkg::detect_idle_state;
            dead_started_d = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= chgdet_pkg::detect_idle_state;
      cnt_q <= '0;
      hw_found_q <= 1'b0;
      dead_started_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      hw_found_q <= hw_found_d;
      dead_started_q <= dead_started_d;
    end
  end

  // Flag pin one cycle behind the register; analogue enables too under takeover, else registered from the machine
  always_comb begin
    // drive to polarity level, else release
    pins_d.pin_oe = ctrl_q.charger_indication;
    pins_d.pin = cfg_q.flag_pin_polarity;
    // D+ source stays on across takeover
    if (ctrl_q.manual_takeover) begin
      pins_d.dplus_src = ctrl_q.dplus_sense_source_enable;
      pins_d.circuit_en = keep_q || ctrl_q.dplus_sense_source_enable;
    end else begin
      pins_d.dplus_src = src_on;
      pins_d.circuit_en = (state_q != chgdet_pkg::detect_idle_state);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_q <= '0;
    end else begin
      pins_q <= pins_d;
    end
  end

  assign charger_flag_pin_o = pins_q.pin;
  assign charger_flag_pin_oe_o = pins_q.pin_oe;
  assign dplus_source_voltage_on_o = pins_q.dplus_src;
  assign detect_circuit_en_o = pins_q.circuit_en;

  // Checks
  chk_found_mirror: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o && ctrl_sel && !ctrl_q.manual_takeover) |=>
      (dat_o[chgdet_pkg::FOUND_BIT] == dat_o[chgdet_pkg::IND_BIT]))
    else $error("port found differs from indication");

  chk_found_forced: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cyc_i && stb_i && !ack_o && ctrl_sel && ctrl_q.manual_takeover) |=>
      !dat_o[chgdet_pkg::FOUND_BIT])
    else $error("port found not forced low under takeover");

  chk_capture_result: assert property (
    @(posedge clk_i) disable iff (rst_i)
    takeover_rise |=> (ctrl_q.charger_indication == $past(hw_found_q))
      ##1 (charger_flag_pin_oe_o == $past(hw_found_q, 2)))
    else $error("indication not captured at takeover");

  chk_capture_source: assert property (
    @(posedge clk_i) disable iff (rst_i)
    takeover_rise |=> (ctrl_q.dplus_sense_source_enable == $past(src_on)))
    else $error("sense enable not captured at takeover");

  chk_machine_parks: assert property (
    @(posedge clk_i) disable iff (rst_i)
    takeover_rise |=> (state_q == chgdet_pkg::detect_idle_state) && !hw_found_q)
    else $error("detection machine not parked at takeover");

  chk_dead_keep: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (takeover_rise && dead_started_q && src_on) |=> ##1
      (detect_circuit_en_o && dplus_source_voltage_on_o))
    else $error("dead battery detection dropped at takeover");

  chk_manual_write: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_ctrl && ctrl_q.manual_takeover && dat_i[chgdet_pkg::MANUAL_BIT]) |=>
      (ctrl_q.charger_indication == $past(dat_i[chgdet_pkg::IND_BIT])))
    else $error("indication write lost under takeover");

  chk_auto_readonly: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!ctrl_q.manual_takeover && !ctrl_d.manual_takeover) |=>
      (ctrl_q.dplus_sense_source_enable == $past(src_on)))
    else $error("sense enable not hardware driven");

  chk_pin_level: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ctrl_q.charger_indication |=>
      (charger_flag_pin_oe_o && (charger_flag_pin_o == $past(cfg_q.flag_pin_polarity))))
    else $error("flag pin not driven to polarity level");

  chk_auto_return: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $fell(ctrl_q.manual_takeover) |-> ##1 (ctrl_q.charger_indication == $past(hw_found_q)))
    else $error("indication not returned to detection");

  chk_ack_single: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");

endmodule
`default_nettype wire

// >>> rtl/chgdet_pkg.sv
// Purpose: Shared constants and types for the charger detect takeover block
// Assumes: 200 MHz register clock, classic Wishbone register access
// Notes: Register offsets are byte addresses of aligned 32-bit words
package chgdet_pkg;

  // Clock and detection timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned SETTLE_TIME_NS = 2000;
  // Least time, so round up to whole cycles
  localparam int unsigned SETTLE_CYC = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 9;
  localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(SETTLE_CYC - 1);

  // Register map
  localparam int unsigned ADR_W = 4;
  localparam logic [ADR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADR_W-1:0] CFG_OFFSET = 4'h4;

  // Control register fields
  localparam int unsigned MANUAL_BIT = 0;
  localparam int unsigned FOUND_BIT = 1;
  localparam int unsigned SPARE_LO = 2;
  localparam int unsigned SPARE_HI = 4;
  localparam int unsigned DM_ABOVE_BIT = 5;
  localparam int unsigned SENSE_BIT = 6;
  localparam int unsigned IND_BIT = 7;

  // Configuration register fields
  localparam int unsigned POL_BIT = 0;
  localparam int unsigned DET_EN_BIT = 1;

  // Reset values
  localparam logic [2:0] SPARE_RESET = 3'h0;
  localparam logic CTRL_BIT_RESET = 1'b0;
  localparam logic CFG_BIT_RESET = 1'b0;

  // Input synchroniser width
  localparam int unsigned SYNC_W = 2;

  typedef enum logic [1:0] {
    detect_idle_state = 2'b00,
    det_source = 2'b01,
    det_sample = 2'b10,
    det_done = 2'b11
  } det_state_e;

  typedef struct packed {
    logic dead_battery;
    logic dm_above_ref;
  } sense_in_s;

  typedef struct packed {
    logic charger_indication;
    logic dplus_sense_source_enable;
    logic [2:0] spare;
    logic manual_takeover;
  } ctrl_s;

  typedef struct packed {
    logic flag_pin_polarity;
    logic detect_enable;
  } cfg_s;

  typedef struct packed {
    logic pin;
    logic pin_oe;
    logic dplus_src;
    logic circuit_en;
  } pins_s;

endpackage

// >>> rtl/pin_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk_i
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [chgdet_pkg::SYNC_W-1:0] async_i,
  output logic [chgdet_pkg::SYNC_W-1:0] sync_o
);

  logic [chgdet_pkg::SYNC_W-1:0] s1_q;
  logic [chgdet_pkg::SYNC_W-1:0] s2_q;
  logic [chgdet_pkg::SYNC_W-1:0] s3_q;
  logic [chgdet_pkg::SYNC_W-1:0] out_d;

  // First stage feeds only the second
  always_comb begin
    out_d = sync_o;
    for (int i = 0; i < chgdet_pkg::SYNC_W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      sync_o <= '0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_o <= out_d;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/charger_detect_sw_takeover_tb_top.sv
// Purpose: Self-checking bench for charger detect takeover
// Assumes: Classic Wishbone master, single clock
// Notes: Expected register contents kept in bench model variables
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: compare mismatch", $time); end end
module charger_detect_sw_takeover_tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [chgdet_pkg::ADR_W-1:0] adr_i = '0;
  logic [31:0] dat_i = '0;
  logic [3:0] sel_i = '0;
  logic we_i = 1'b0;
  logic cyc_i = 1'b0;
  logic stb_i = 1'b0;
  chgdet_pkg::sense_in_s sense = '0;
  logic [31:0] dat_o;
  logic ack_o, pin_o, oe_o, src_o, cen_o, flag_wire, flag_on;
  logic pol = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  logic m_man = 1'b0;
  logic m_ind = 1'b0;
  logic m_sense = 1'b0;
  logic [2:0] m_spare = 3'h0;
  logic [31:0] rd;

  charger_detect_sw_takeover u_charger_detect_sw_takeover (
    .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o),
    .sel_i(sel_i), .we_i(we_i), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
    .detect_sense_i(sense), .charger_flag_pin_o(pin_o), .charger_flag_pin_oe_o(oe_o),
    .dplus_source_voltage_on_o(src_o), .detect_circuit_en_o(cen_o)
  );
  charger_model u_charger_model (
    .pin_i(pin_o), .oe_i(oe_o), .pol_i(pol), .wire_o(flag_wire), .asserted_o(flag_on)
  );

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Holds the request until ack is sampled, then releases at that edge
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s, output logic [31:0] q);
    int i;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (ack_o === 1'b1) break;
    end
    q = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    if (i == 20) begin
      n_fail++;
      conclude();
    end
  endtask

  function automatic logic [31:0] exp_ctrl();
    return {24'h0, m_ind, m_sense, sense.dm_above_ref, m_spare, m_ind & ~m_man, m_man};
  endfunction

  task automatic rd_ctrl();
    wb(1'b0, chgdet_pkg::CTRL_OFFSET, 32'h0, 4'hf, rd);
    `CHECK(rd, exp_ctrl())
  endtask

  task automatic wr_ctrl();
    wb(1'b1, chgdet_pkg::CTRL_OFFSET, {24'h0, m_ind, m_sense, 1'b0, m_spare, 1'b0, m_man},
       4'h1, rd);
  endtask

  // Polls the indication bit; detection takes hundreds of cycles
  task automatic wait_ind();
    int j;
    for (j = 0; j < 300; j++) begin
      wb(1'b0, chgdet_pkg::CTRL_OFFSET, 32'h0, 4'hf, rd);
      if (rd[chgdet_pkg::IND_BIT] === 1'b1) break;
    end
    if (j == 300) begin
      n_fail++;
      conclude();
    end
  endtask

  initial begin
    #250us;
    n_fail++;
    conclude();
  end

  initial begin
    logic [31:0] d;
    logic [3:0] s;
    void'($urandom(32'h5956));
    idle(10);
    rst_i <= 1'b0;
    rd_ctrl();
    wb(1'b0, chgdet_pkg::CFG_OFFSET, 32'h0, 4'hf, rd);
    `CHECK(rd, 32'h0)
    wb(1'b0, 4'h8, 32'h0, 4'hf, rd);
    `CHECK(rd, 32'h0)
    wb(1'b1, 4'hc, 32'hff, 4'hf, rd);
    for (int k = 0; k < 8; k++) begin
      d = $urandom();
      d[0] = 1'b0;
      s = $urandom();
      if (s[0]) m_spare = d[4:2];
      wb(1'b1, chgdet_pkg::CTRL_OFFSET, d, s, rd);
      rd_ctrl();
    end
    // Automatic detection, active-high flag
    sense <= 2'b01;
    pol <= 1'b1;
    wb(1'b1, chgdet_pkg::CFG_OFFSET, 32'h3, 4'h1, rd);
    wb(1'b0, chgdet_pkg::CFG_OFFSET, 32'h0, 4'hf, rd);
    `CHECK(rd, 32'h3)
    idle(10);
    `CHECK(src_o, 1'b1)
    `CHECK(oe_o, 1'b0)
    wait_ind();
    m_ind = 1'b1;
    rd_ctrl();
    idle(4);
    `CHECK(flag_on, 1'b1)
    `CHECK(pin_o, 1'b1)
    `CHECK(src_o, 1'b0)
    // Takeover alone, indication left as it reads
    m_man = 1'b1;
    wr_ctrl();
    rd_ctrl();
    idle(4);
    `CHECK(flag_on, 1'b1)
    `CHECK(src_o, 1'b0)
    m_sense = 1'b1;
    wr_ctrl();
    rd_ctrl();
    idle(4);
    `CHECK(src_o, 1'b1)
    `CHECK(cen_o, 1'b1)
    m_ind = 1'b0;
    wr_ctrl();
    rd_ctrl();
    idle(4);
    `CHECK(flag_on, 1'b0)
    `CHECK(oe_o, 1'b0)
    m_man = 1'b0;
    m_sense = 1'b0;
    wr_ctrl();
    wait_ind();
    m_ind = 1'b1;
    rd_ctrl();
    idle(4);
    `CHECK(flag_on, 1'b1)
    // Reset in mid-run, then a dead-battery start with active-low flag
    rst_i <= 1'b1;
    idle(10);
    rst_i <= 1'b0;
    pol <= 1'b0;
    m_ind = 1'b0;
    m_spare = 3'h0;
    // Sense pins need four edges through the synchroniser after reset
    idle(5);
    rd_ctrl();
    `CHECK(oe_o, 1'b0)
    sense <= 2'b11;
    idle(10);
    `CHECK(src_o, 1'b1)
    wait_ind();
    m_ind = 1'b1;
    m_sense = 1'b1;
    rd_ctrl();
    idle(4);
    `CHECK(pin_o, 1'b0)
    `CHECK(flag_wire, 1'b0)
    `CHECK(flag_on, 1'b1)
    m_man = 1'b1;
    wr_ctrl();
    rd_ctrl();
    idle(4);
    `CHECK(flag_on, 1'b1)
    `CHECK(src_o, 1'b1)
    `CHECK(cen_o, 1'b1)
    conclude();
  end
endmodule
`default_nettype wire

// >>> testbench/charger_model.sv
// Purpose: External charger watching the charger flag pin
// Assumes: Released pin is pulled to the inactive level
// Notes: Active level of the pin equals the polarity setting
`timescale 1ns/1ps
`default_nettype none
module charger_model (
  input wire logic pin_i,
  input wire logic oe_i,
  input wire logic pol_i,
  output logic wire_o,
  output logic asserted_o
);
  // released pin pulled
  // Pull opposes the active level, so a release never reads as a request
  assign wire_o = oe_i ? pin_i : ~pol_i;
  assign asserted_o = (wire_o == pol_i);
endmodule
`default_nettype wire
